// ===== rtl/pin_drive_pkg.sv
// ============================================================
// Package for the address and data pin drive controller.
// Assumes an APB slave with 32-bit data and a 100 MHz sys_clk_i.
package pin_drive_pkg;

    // ============================================================
    // Register indices and byte addresses
    localparam logic [7:0] IDX_CFG_A = 8'h14;
    localparam logic [7:0] IDX_CFG_B = 8'h15;
    localparam logic [7:0] IDX_CFG_C = 8'h16;
    localparam int WORD_BYTES = 4;
    localparam logic [7:0] ADDR_CFG_A = 8'(IDX_CFG_A * WORD_BYTES);
    localparam logic [7:0] ADDR_CFG_B = 8'(IDX_CFG_B * WORD_BYTES);
    localparam logic [7:0] ADDR_CFG_C = 8'(IDX_CFG_C * WORD_BYTES);

    // ============================================================
    // Field positions and masks
    localparam int PIN_HI_FIELD = 5;   // Low bit of {ram, first rom, second rom} for upper pin
    localparam int PIN_LO_FIELD = 1;   // Same for lower pin of the pair
    localparam int FIELD_W = 3;
    localparam int SEL_RAM = 2;
    localparam int SEL_FIRST_ROM = 1;
    localparam int SEL_SECOND_ROM = 0;
    localparam int MID_DRAM_BIT = 7;   // mid_addr_dram_latch_sel
    localparam int IO_LATCH_BIT = 6;   // io_cycle_addr_latch_sel
    localparam int CLAMP_BIT = 3;      // data_clamp_low_en
    localparam int KEEPER_BIT = 2;     // data_bus_keeper_en
    localparam logic [7:0] CFG_AB_MASK = 8'hEE;
    localparam logic [7:0] CFG_C_MASK = 8'hCC;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // ============================================================
    // Pin geometry
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int PIN_LOW = 12;       // Lowest address pin handled here
    localparam int UPPER_PINS = 4;     // Pins 23..20 with per-cycle config
    localparam int IO_PIN_LOW = 16;
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;

    // Bus cycle kinds
    typedef enum logic [2:0] {
        CYC_IDLE = 3'b000,
        CYC_RAM = 3'b001,
        CYC_FIRST_ROM = 3'b010,        // first_rom_cycle
        CYC_SECOND_ROM = 3'b011,       // second_rom_cycle
        CYC_DRAM = 3'b100,
        CYC_IO = 3'b101,
        CYC_PCCARD = 3'b110
    } cycle_type;

endpackage

// ===== rtl/cycle_capture.sv
// ============================================================
// Holding latch for the last bus address and last data value.
// Assumes cycle_done_i is a one-cycle pulse in sys_clk_i domain.
`timescale 1ns/1ps
module cycle_capture (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic cycle_done_i,
    input wire logic cycle_write_i,
    input wire logic [pin_drive_pkg::ADDR_W-1:0] mapper_addr_i,
    input wire logic [pin_drive_pkg::DATA_W-1:0] cpu_data_i,
    input wire logic [pin_drive_pkg::DATA_W-1:0] data_pin_i,
    output logic [pin_drive_pkg::ADDR_W-1:0] last_addr_o,
    output logic [pin_drive_pkg::DATA_W-1:0] last_data_o
);

    logic [pin_drive_pkg::DATA_W-1:0] din_meta_ff, din_sync_ff;
    logic [pin_drive_pkg::DATA_W-1:0] nxt_din_meta, nxt_din_sync, nxt_last_data;
    logic [pin_drive_pkg::ADDR_W-1:0] nxt_last_addr;

    // ============================================================
    // Pin synchroniser and capture of completed cycles
    always_comb begin
        nxt_din_meta = data_pin_i;
        nxt_din_sync = din_meta_ff;
        nxt_last_addr = last_addr_o;
        nxt_last_data = last_data_o;
        if (cycle_done_i) begin
            nxt_last_addr = mapper_addr_i;
            nxt_last_data = cycle_write_i ? cpu_data_i : din_sync_ff;
        end
    end

    // Registers frozen while ce_i is low
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            din_meta_ff <= '0;
            din_sync_ff <= '0;
            last_addr_o <= '0;
            last_data_o <= '0;
        end else if (ce_i) begin
            din_meta_ff <= nxt_din_meta;
            din_sync_ff <= nxt_din_sync;
            last_addr_o <= nxt_last_addr;
            last_data_o <= nxt_last_data;
        end
    end

    a_addr_capture: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        ce_i && cycle_done_i |=> last_addr_o == $past(mapper_addr_i))
        else $error("last address not captured");

endmodule

// ===== rtl/address_data_pin_drive_ctrl.sv
// ============================================================
// Drive control for address pins 23..12 and data pins 15..0.
// Assumes APB master on sys_clk_i; cycle inputs come from on-chip logic.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module address_data_pin_drive_ctrl (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [pin_drive_pkg::APB_AW-1:0] paddr_i,
    input wire logic [pin_drive_pkg::APB_DW-1:0] pwdata_i,
    output logic [pin_drive_pkg::APB_DW-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [2:0] cycle_type_i,
    input wire logic cycle_done_i,
    input wire logic cycle_write_i,
    input wire logic [pin_drive_pkg::ADDR_W-1:0] mapper_addr_i,
    input wire logic [pin_drive_pkg::DATA_W-1:0] cpu_data_i,
    input wire logic [pin_drive_pkg::DATA_W-1:0] data_pin_i,
    input wire logic pccard_pwr_i,
    input wire logic stop_clk_i,
    output logic [pin_drive_pkg::ADDR_W-1:pin_drive_pkg::PIN_LOW] addr_pin_o,
    output logic [pin_drive_pkg::ADDR_W-1:pin_drive_pkg::PIN_LOW] addr_pin_oe_o,
    output logic [pin_drive_pkg::DATA_W-1:0] data_pin_o,
    output logic data_pin_oe_o
);

    localparam int AH = pin_drive_pkg::ADDR_W - 1;
    localparam int AL = pin_drive_pkg::PIN_LOW;

    // ============================================================
    // Helper functions

    // Config field {ram, first rom, second rom} of upper pin k (0 is pin 23)
    function automatic logic [2:0] pin_cfg(input logic [7:0] cfg_a, input logic [7:0] cfg_b, input int k);
        logic [7:0] reg_v;
        int lo;
        reg_v = (k < 2) ? cfg_a : cfg_b;
        lo = (k % 2 == 0) ? pin_drive_pkg::PIN_HI_FIELD : pin_drive_pkg::PIN_LO_FIELD;
        return reg_v[lo +: pin_drive_pkg::FIELD_W];
    endfunction

    // Picks the latched address bit when the latch select is set
    function automatic logic pick(input logic sel, input logic latched, input logic mapper);
        return sel ? latched : mapper;
    endfunction

    // ============================================================
    // Register file and APB slave
    logic [7:0] cfg_a_ff, cfg_b_ff, cfg_c_ff;
    logic [7:0] nxt_cfg_a, nxt_cfg_b, nxt_cfg_c;
    logic [pin_drive_pkg::APB_DW-1:0] nxt_prdata;
    logic nxt_pready, nxt_pslverr;
    logic setup_phase, wr_commit, hit_a, hit_b, hit_c;

    assign setup_phase = psel_i && !penable_i && !pready_o;
    assign wr_commit = psel_i && penable_i && pready_o && pwrite_i;
    assign hit_a = (paddr_i == pin_drive_pkg::ADDR_CFG_A);
    assign hit_b = (paddr_i == pin_drive_pkg::ADDR_CFG_B);
    assign hit_c = (paddr_i == pin_drive_pkg::ADDR_CFG_C);

    // Answer one cycle after setup; writes land at the completing edge
    always_comb begin
        nxt_cfg_a = cfg_a_ff;
        nxt_cfg_b = cfg_b_ff;
        nxt_cfg_c = cfg_c_ff;
        nxt_pready = setup_phase;
        nxt_pslverr = 1'b0;
        nxt_prdata = prdata_o;
        if (setup_phase) begin
            nxt_prdata = '0;
            if (hit_a) begin
                nxt_prdata[7:0] = cfg_a_ff;
            end else if (hit_b) begin
                nxt_prdata[7:0] = cfg_b_ff;
            end else if (hit_c) begin
                nxt_prdata[7:0] = cfg_c_ff;
            end else begin
                nxt_pslverr = 1'b1;
            end
        end
        if (wr_commit) begin
            if (hit_a) begin
                nxt_cfg_a = pwdata_i[7:0] & pin_drive_pkg::CFG_AB_MASK;
            end else if (hit_b) begin
                nxt_cfg_b = pwdata_i[7:0] & pin_drive_pkg::CFG_AB_MASK;
            end else if (hit_c) begin
                nxt_cfg_c = pwdata_i[7:0] & pin_drive_pkg::CFG_C_MASK;
            end
        end
    end

    // Register stage for the bus slave
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_a_ff <= pin_drive_pkg::CFG_RESET;
            cfg_b_ff <= pin_drive_pkg::CFG_RESET;
            cfg_c_ff <= pin_drive_pkg::CFG_RESET;
            prdata_o <= '0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (ce_i) begin
            cfg_a_ff <= nxt_cfg_a;
            cfg_b_ff <= nxt_cfg_b;
            cfg_c_ff <= nxt_cfg_c;
            prdata_o <= nxt_prdata;
            pready_o <= nxt_pready;
            pslverr_o <= nxt_pslverr;
        end
    end

    // ============================================================
    // Holding latch for last address and data
    logic [pin_drive_pkg::ADDR_W-1:0] last_addr;
    logic [pin_drive_pkg::DATA_W-1:0] last_data;

    cycle_capture u_capture (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .cycle_done_i(cycle_done_i),
        .cycle_write_i(cycle_write_i),
        .mapper_addr_i(mapper_addr_i),
        .cpu_data_i(cpu_data_i),
        .data_pin_i(data_pin_i),
        .last_addr_o(last_addr),
        .last_data_o(last_data)
    );

    // ============================================================
    // Address pin drive
    logic [AH:AL] nxt_addr, nxt_addr_oe;
    pin_drive_pkg::cycle_type cyc;

    assign cyc = pin_drive_pkg::cycle_type'(cycle_type_i);

    // Per-pin source and enable for the current cycle kind
    always_comb begin
        logic [2:0] f;
        int p;
        f = '0;
        p = 0;
        nxt_addr = mapper_addr_i[AH:AL];
        nxt_addr_oe = '1;
        for (int k = 0; k < pin_drive_pkg::UPPER_PINS; k++) begin
            f = pin_cfg(cfg_a_ff, cfg_b_ff, k);
            p = AH - k;
            case (cyc)
                pin_drive_pkg::CYC_RAM: begin
                    nxt_addr[p] = pick(f[pin_drive_pkg::SEL_RAM], last_addr[p], mapper_addr_i[p]);
                end
                pin_drive_pkg::CYC_FIRST_ROM: begin
                    nxt_addr[p] = pick(f[pin_drive_pkg::SEL_FIRST_ROM], last_addr[p], mapper_addr_i[p]);
                end
                pin_drive_pkg::CYC_SECOND_ROM: begin
                    nxt_addr[p] = pick(f[pin_drive_pkg::SEL_SECOND_ROM], last_addr[p], mapper_addr_i[p]);
                end
                default: begin
                    nxt_addr[p] = mapper_addr_i[p];
                end
            endcase
            // Slot pins go high impedance with card power off, except on a card cycle
            if (f == 3'h0 && !pccard_pwr_i && cyc != pin_drive_pkg::CYC_PCCARD) begin
                nxt_addr_oe[p] = 1'b0;
            end
        end
        if (cyc == pin_drive_pkg::CYC_DRAM && cfg_c_ff[pin_drive_pkg::MID_DRAM_BIT]) begin
            nxt_addr[pin_drive_pkg::IO_PIN_LOW+3:AL] = last_addr[pin_drive_pkg::IO_PIN_LOW+3:AL];
        end
        if (cyc == pin_drive_pkg::CYC_IO) begin
            if (cfg_c_ff[pin_drive_pkg::IO_LATCH_BIT]) begin
                nxt_addr[pin_drive_pkg::IO_PIN_LOW+3:pin_drive_pkg::IO_PIN_LOW] =
                    last_addr[pin_drive_pkg::IO_PIN_LOW+3:pin_drive_pkg::IO_PIN_LOW];
            end else begin
                nxt_addr[pin_drive_pkg::IO_PIN_LOW+3:pin_drive_pkg::IO_PIN_LOW] = 4'h0;
            end
        end
    end

    // ============================================================
    // Data pin drive
    logic [pin_drive_pkg::DATA_W-1:0] nxt_data;
    logic nxt_data_oe;

    // Stop clock beats idle and active cycles; otherwise active cycles drive only on writes
    always_comb begin
        nxt_data = cpu_data_i;
        nxt_data_oe = cycle_write_i;
        if (stop_clk_i) begin
            nxt_data = '0;
            nxt_data_oe = cfg_c_ff[pin_drive_pkg::CLAMP_BIT];
        end else if (cyc == pin_drive_pkg::CYC_IDLE) begin
            nxt_data = last_data;
            nxt_data_oe = cfg_c_ff[pin_drive_pkg::KEEPER_BIT];
        end
    end

    // Pin output registers
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_pin_o <= '0;
            addr_pin_oe_o <= '0;
            data_pin_o <= '0;
            data_pin_oe_o <= 1'b0;
        end else if (ce_i) begin
            addr_pin_o <= nxt_addr;
            addr_pin_oe_o <= nxt_addr_oe;
            data_pin_o <= nxt_data;
            data_pin_oe_o <= nxt_data_oe;
        end
    end

    // ============================================================
    // Assertions and cover points
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_card_top_pins: assert property (
        ce_i && cyc == pin_drive_pkg::CYC_PCCARD |=> addr_pin_oe_o[AH -: 2] == 2'b11
            && addr_pin_o[AH -: 2] == $past(mapper_addr_i[AH -: 2]))
        else $error("top address pins not driven on card cycle");

    a_slot_pin_float: assert property (
        ce_i && !pccard_pwr_i && cyc != pin_drive_pkg::CYC_PCCARD
            && pin_cfg(cfg_a_ff, cfg_b_ff, 0) == 3'h0 |=> !addr_pin_oe_o[AH])
        else $error("slot pin driven with card power off");

    a_cfg_a_write: assert property (
        ce_i && wr_commit && hit_a |=> cfg_a_ff == ($past(pwdata_i[7:0]) & pin_drive_pkg::CFG_AB_MASK))
        else $error("first config register write lost");

    a_cfg_b_read: assert property (
        psel_i && penable_i && pready_o && !pwrite_i && hit_b |-> prdata_o == {24'h0, cfg_b_ff})
        else $error("second config register read mismatch");

    a_ram_latch_pin: assert property (
        ce_i && cyc == pin_drive_pkg::CYC_RAM && cfg_a_ff[7] |=> addr_pin_o[AH] == $past(last_addr[AH]))
        else $error("pin 23 not latched on RAM cycle");

    a_rom_mapper_pin: assert property (
        ce_i && cyc == pin_drive_pkg::CYC_FIRST_ROM && !cfg_a_ff[2]
            |=> addr_pin_o[AH-1] == $past(mapper_addr_i[AH-1]))
        else $error("pin 22 not mapper on first ROM cycle");

    a_rom2_latch_pin: assert property (
        ce_i && cyc == pin_drive_pkg::CYC_SECOND_ROM && cfg_b_ff[5]
            |=> addr_pin_o[AH-2] == $past(last_addr[AH-2]))
        else $error("pin 21 not latched on second ROM cycle");

    a_dram_mid_pins: assert property (
        ce_i && cyc == pin_drive_pkg::CYC_DRAM && cfg_c_ff[pin_drive_pkg::MID_DRAM_BIT]
            |=> addr_pin_o[19:AL] == $past(last_addr[19:AL]))
        else $error("mid pins not latched on DRAM cycle");

    a_io_pins_low: assert property (
        ce_i && cyc == pin_drive_pkg::CYC_IO && !cfg_c_ff[pin_drive_pkg::IO_LATCH_BIT]
            |=> addr_pin_o[19:16] == 4'h0)
        else $error("I/O pins not low");

    a_stop_clamp: assert property (
        ce_i && stop_clk_i |=> data_pin_oe_o == $past(cfg_c_ff[pin_drive_pkg::CLAMP_BIT])
            && data_pin_o == '0)
        else $error("data clamp wrong in stop clock");

    a_idle_keeper: assert property (
        ce_i && !stop_clk_i && cyc == pin_drive_pkg::CYC_IDLE && cfg_c_ff[pin_drive_pkg::KEEPER_BIT]
            |=> data_pin_oe_o && data_pin_o == $past(last_data))
        else $error("idle data not held");

    a_reset_clear: assert property (
        !$past(nrst_i) |-> cfg_a_ff == '0 && cfg_b_ff == '0 && cfg_c_ff == '0)
        else $error("config not cleared by reset");

    c_card_cycle: cover property (ce_i && cyc == pin_drive_pkg::CYC_PCCARD ##1 addr_pin_oe_o[AH]);
    c_cfg_write: cover property (wr_commit && hit_c);
    c_stop_clamp: cover property (stop_clk_i && cfg_c_ff[pin_drive_pkg::CLAMP_BIT] ##1 data_pin_oe_o);
    c_bad_addr: cover property (pslverr_o && pready_o);

endmodule

// ===== dv/slot_memory_model.sv
// Model of the memories and card slot that share the data pins.
// Assumes the controller's data outputs and the one system clock.
`timescale 1ns/1ps
module slot_memory_model (
    input wire logic sys_clk_i,
    input wire logic [2:0] cycle_type_i,
    input wire logic cycle_write_i,
    input wire logic [15:0] dev_data_i,
    input wire logic dev_oe_i,
    output logic [15:0] wire_data_o
);
    logic [15:0] drv_ff = 16'h5A5A;
    logic [15:0] cnt_ff = 16'h0000;

    // Reads return a moving pattern; a released bus never keeps its last value
    always @(posedge sys_clk_i) begin
        cnt_ff <= cnt_ff + 16'h0001;
        if (cycle_type_i != 3'h0 && !cycle_write_i) begin
            drv_ff <= {cnt_ff[7:0], ~cnt_ff[7:0]};
        end else begin
            drv_ff <= ~drv_ff;
        end
    end

    // Wire level: the controller wins while it drives
    assign wire_data_o = dev_oe_i ? dev_data_i : drv_ff;
endmodule

// ===== dv/test_address_data_pin_drive_ctrl.sv
// Self-checking bench for the address and data pin drive controller.
// Assumes the controller, its package and the slot model are compiled first.
`timescale 1ns/1ps
module test_address_data_pin_drive_ctrl;
    // ============================================================
    // Signals and prediction state
    logic sys_clk_i = 1'b0;
    logic nrst_i, ce_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic cycle_done_i, cycle_write_i, pccard_pwr_i, stop_clk_i, data_pin_oe_o;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, seed, rd, w;
    logic [2:0] cycle_type_i;
    logic [23:0] mapper_addr_i, lat;
    logic [15:0] cpu_data_i, data_pin_i, data_pin_o, ld, ed, pm, ps;
    logic [23:12] addr_pin_o, addr_pin_oe_o;
    logic [11:0] ea, eo, em;
    logic [7:0] cfgm [3];
    logic [7:0] e8;
    logic err, deo, have_exp, chk_on;
    int bad_count, check_count;

    always #5 sys_clk_i = ~sys_clk_i;

    address_data_pin_drive_ctrl address_data_pin_drive_ctrl_i (.sys_clk_i, .nrst_i, .ce_i, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cycle_type_i,
        .cycle_done_i, .cycle_write_i, .mapper_addr_i, .cpu_data_i, .data_pin_i, .pccard_pwr_i,
        .stop_clk_i, .addr_pin_o, .addr_pin_oe_o, .data_pin_o, .data_pin_oe_o);

    slot_memory_model slot_memory_model_i (.sys_clk_i, .cycle_type_i, .cycle_write_i,
        .dev_data_i(data_pin_o), .dev_oe_i(data_pin_oe_o), .wire_data_o(data_pin_i));

    // ============================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] adr(input int j);
        return pin_drive_pkg::ADDR_CFG_A + 8'(4 * j);
    endfunction

    // Expected pins for this edge's inputs; mode 1 float, 2 mapper, 3 latch, 4 low
    function automatic void predict();
        logic [2:0] f;
        int md;
        for (int p = 12; p < 24; p++) begin
            f = 3'((p > 21 ? cfgm[0] : cfgm[1]) >> (p % 2 ? 5 : 1));
            md = 0;
            if (p > 19 && f == 3'h0 && !pccard_pwr_i && cycle_type_i != pin_drive_pkg::CYC_PCCARD) md = 1;
            else case (cycle_type_i)
                pin_drive_pkg::CYC_RAM: if (p > 19) md = f[2] ? 3 : 2;
                pin_drive_pkg::CYC_FIRST_ROM: if (p > 19) md = f[1] ? 3 : 2;
                pin_drive_pkg::CYC_SECOND_ROM: if (p > 19) md = f[0] ? 3 : 2;
                pin_drive_pkg::CYC_DRAM: if (p < 20) md = cfgm[2][7] ? 3 : 2;
                pin_drive_pkg::CYC_IO: md = p < 16 ? 2 : (p < 20 ? (cfgm[2][6] ? 3 : 4) : 0);
                pin_drive_pkg::CYC_PCCARD: md = 2;
                default: md = 0;
            endcase
            em[p-12] = md != 0;
            eo[p-12] = md > 1;
            ea[p-12] = md == 3 ? lat[p] : (md == 2 ? mapper_addr_i[p] : 1'b0);
        end
        // Outside stop clock, active cycles drive the CPU word on writes only
        ed = cpu_data_i;
        deo = cycle_write_i;
        if (stop_clk_i) begin
            deo = cfgm[2][3];
            ed = 16'h0000;
        end else if (cycle_type_i == 3'h0) begin
            deo = cfgm[2][2];
            ed = ld;
        end
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // One APB transfer; psel stays up so a next transfer may follow at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk("apb_timeout", 32'h0000_0000, 32'h0000_0001);
            close_out();
        end else begin
            rd = prdata_o;
            err = pslverr_o;
            penable_i <= 1'b0;
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0000_0000);
        chk("prdata", rd, e);
        chk("pslverr", {31'h0, err}, {31'h0, ee});
    endtask

    task automatic do_reset();
        nrst_i <= 1'b0;
        repeat (16) @(posedge sys_clk_i);
        chk("reset_out", 32'({addr_pin_oe_o, data_pin_oe_o, pready_o}), 32'h0000_0000);
        nrst_i <= 1'b1;
        @(posedge sys_clk_i);
        for (int j = 0; j < 3; j++) rdchk(adr(j), 32'h0000_0000, 1'b0);
    endtask

    // Random bus cycles with short clock-enable gaps
    task automatic run_rand(input int n);
        logic [31:0] r;
        logic [2:0] t;
        repeat (n) begin
            @(posedge sys_clk_i);
            r = rnd();
            t = 3'(r % 7);
            cycle_type_i <= t;
            cycle_done_i <= r[4] && t != 3'h0;
            cycle_write_i <= r[5];
            pccard_pwr_i <= r[6];
            stop_clk_i <= r[8:7] == 2'h0 && t == 3'h0;
            ce_i <= r[11:9] != 3'h0;
            cpu_data_i <= r[31:16];
            mapper_addr_i <= 24'(rnd());
        end
        @(posedge sys_clk_i);
        ce_i <= 1'b1;
        chk_on <= 1'b0;
    endtask

    // ============================================================
    // Pin monitor: compare with the last prediction, then predict again
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            have_exp <= 1'b0;
            lat <= 24'h00_0000;
            ld <= 16'h0000;
            pm <= 16'h0000;
            ps <= 16'h0000;
        end else begin
            if (chk_on && have_exp) begin
                chk("addr_val", 32'(addr_pin_o & em & eo), 32'(ea & em & eo));
                chk("addr_oe", 32'(addr_pin_oe_o & em), 32'(eo & em));
                chk("data_val", 32'(data_pin_o & {16{deo}}), 32'(ed & {16{deo}}));
                chk("data_oe", 32'(data_pin_oe_o), 32'(deo));
            end
            if (ce_i) begin
                predict();
                have_exp <= 1'b1;
                // Data pins reach the holding latch two enabled edges late
                pm <= data_pin_i;
                ps <= pm;
                if (cycle_done_i) begin
                    lat <= mapper_addr_i;
                    ld <= cycle_write_i ? cpu_data_i : ps;
                end
            end
        end
    end

    // ============================================================
    // Main sequence
    initial begin
        nrst_i = 1'b0;
        ce_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0000_0000;
        cycle_type_i = 3'h0;
        cycle_done_i = 1'b0;
        cycle_write_i = 1'b0;
        mapper_addr_i = 24'h00_0000;
        cpu_data_i = 16'h0000;
        pccard_pwr_i = 1'b0;
        stop_clk_i = 1'b0;
        seed = 32'h0000_0062;
        chk_on = 1'b0;
        bad_count = 0;
        check_count = 0;
        do_reset();
        for (int k = 0; k < 14; k++) begin
            if (k == 7) do_reset();
            apb(1'b1, 8'h5C, 32'hFFFF_FFFF);
            chk("unmapped_wr", {31'h0, err}, 32'h0000_0001);
            rdchk(8'h5C, 32'h0000_0000, 1'b1);
            // All zero, all one, then random settings, each read back
            for (int j = 0; j < 3; j++) begin
                w = k == 1 ? 32'hFFFF_FFFF : (k == 0 ? 32'h0000_0000 : rnd());
                apb(1'b1, adr(j), w);
                e8 = 8'(w) & (j == 2 ? pin_drive_pkg::CFG_C_MASK : pin_drive_pkg::CFG_AB_MASK);
                rdchk(adr(j), {24'h0, e8}, 1'b0);
                cfgm[j] = e8;
            end
            psel_i <= 1'b0;
            repeat (2) @(posedge sys_clk_i);
            chk_on <= 1'b1;
            run_rand(60);
        end
        close_out();
    end
endmodule
